// >>> src/isc_top.sv
// Interrupt source controller: flags, masks, priority, vector, pin muxing
`timescale 1ns/1ps
// Overview of operation
// - Only the highest fixed-priority pending request is presented.
// - Global mask set: flags still set, no interrupt accepted.
// - External inputs 4, 1, 0 have selectable edge polarity.
// - External inputs 5, 3, 2 detect falling edges only.
// - Reset at 0x0000, external 0..5 at 0x0008..0x0012, priority descending.
// - Key scan, timers A-E, transition, serial 1/2, A/D follow in order.
// - Oscillator-wait done after sleep raises transition request at 0x0020.
// - Vectors 0x0002-0x0006 and 0x0022-0x0024 are never produced.
// - Request flags clear on written zero; written one leaves flag.
// - Mode bit 7 enables 256-state noise filter on input 0.
// - Mode bit 6 selects port pin or event counter input.
// - Mode bit 5 routes shared pin to port/timer or input 5.
// - Mode bits 5..0 pick port pin or external request input.
// - Registers reset to 00, EC, C0, 00, 3C, C0, 00, 3C.
// - Polarity bit 0 selects falling edge, 1 rising edge.
// - External enable bit passes its flag when one, blocks when zero.
// - Accepted interrupt waits for the current instruction to end.
module isc_top
  import isc_pkg::*;
#(
  parameter int FILT_STATES = ISC_FILT_STATES
) (
  input  wire logic        sys_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [15:0] avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [7:0]  avs_writedata_i,
  output logic      [7:0]  avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic [6:0]  port1_pins_i,
  input  wire logic        global_mask_i,
  input  wire logic        insn_done_i,
  input  wire logic        irq_ack_i,
  input  wire logic        key_scan_req_i,
  input  wire logic [4:0]  timer_ovf_req_i,
  input  wire logic        osc_wait_done_i,
  input  wire logic        serial_one_req_i,
  input  wire logic        serial_two_req_i,
  input  wire logic        adc_done_req_i,
  output logic             irq_req_o,
  output logic [15:0]      irq_vector_o,
  output logic             event_count_o,
  output logic             event_sel_o,
  output logic [5:0]       port_gpio_sel_o
);

  // Slot index per source; vector = EXT0 + 2*slot, skipping reserved pair
  function automatic logic [15:0] vec_of(input logic [3:0] idx);
    logic [15:0] base;
    base = ISC_VEC_EXT0 + {11'h000, idx, 1'b0};
    if (idx > 4'hC)
      base = base + 16'h0004;
    return base;
  endfunction

  logic [7:0]  pmr_reg;
  logic [7:0]  edge_reg;
  logic [7:0]  en1_reg;
  logic [7:0]  en2_reg;
  logic [7:0]  en3_reg;
  logic [7:0]  req1_reg;
  logic [7:0]  req2_reg;
  logic [7:0]  req3_reg;
  logic [7:0]  req1_next;
  logic [7:0]  req2_next;
  logic [7:0]  req3_next;
  logic [6:0]  pin_prev_reg;
  logic        osc_prev_reg;
  logic [7:0]  filt_cnt_reg;
  logic        filt_samp_reg;
  logic        filt_out_reg;
  logic        ext0_prev_reg;
  logic [3:0]  pend_idx_reg;
  logic [7:0]  rdata_reg;
  logic        irq_reg;
  logic [15:0] vec_reg;
  logic        event_reg;
  isc_bus_t    bus_state_reg;

  // Bus decode
  wire logic bus_req   = avs_read_i | avs_write_i;
  // Write lands at the completing edge, where waitrequest is low
  wire logic wr_take   = avs_write_i && (bus_state_reg == ISC_BUS_DONE);
  wire logic hit_pmr   = avs_address_i == ISC_PMR_ADDR;
  wire logic hit_edge  = avs_address_i == ISC_EDGE_ADDR;
  wire logic hit_en1   = avs_address_i == ISC_EN1_ADDR;
  wire logic hit_en2   = avs_address_i == ISC_EN2_ADDR;
  wire logic hit_en3   = avs_address_i == ISC_EN3_ADDR;
  wire logic hit_req1  = avs_address_i == ISC_REQ1_ADDR;
  wire logic hit_req2  = avs_address_i == ISC_REQ2_ADDR;
  wire logic hit_req3  = avs_address_i == ISC_REQ3_ADDR;
  wire logic hit_stat  = avs_address_i == ISC_STAT_ADDR;
  wire logic [7:0] wd  = avs_writedata_i;

  // Noise filter on input 0: sample every FILT_STATES, accept on two agree
  wire logic filt_tick = filt_cnt_reg == 8'(FILT_STATES - 1);
  wire logic noise_on  = pmr_reg[ISC_PMR_NOISE];
  wire logic ext0_lvl  = noise_on ? filt_out_reg : port1_pins_i[0];

  // Edge detection with polarity
  wire logic [5:0] cur_lvl  = {port1_pins_i[5:1], ext0_lvl};
  wire logic [5:0] prv_lvl  = {pin_prev_reg[5:1], ext0_prev_reg};
  wire logic [5:0] fall     = prv_lvl & ~cur_lvl;
  wire logic [5:0] rise     = ~prv_lvl & cur_lvl;
  // Inputs 5,3,2 fixed falling; 4,1,0 follow polarity bits
  wire logic [5:0] pol_rise = edge_reg[5:0] & 6'h13;
  wire logic [5:0] ext_edge = (pol_rise & rise) | (~pol_rise & fall);
  wire logic [5:0] ext_set  = ext_edge & pmr_reg[5:0];
  wire logic dirt_set = osc_wait_done_i & ~osc_prev_reg;

  // Flag next values: hardware set wins over software clear
  wire logic [7:0] clr1 = (wr_take && hit_req1) ? ~wd : 8'h00;
  wire logic [7:0] clr2 = (wr_take && hit_req2) ? ~wd : 8'h00;
  wire logic [7:0] clr3 = (wr_take && hit_req3) ? ~wd : 8'h00;
  wire logic [7:0] set1 = {2'b00, ext_set};
  wire logic [7:0] set2 = {2'b00, dirt_set, timer_ovf_req_i};
  wire logic [7:0] set3 = {adc_done_req_i, serial_two_req_i, 4'h0,
                           serial_one_req_i, key_scan_req_i};

  assign req1_next = (((req1_reg & ~clr1) | set1) & 8'h3F) | ISC_BANK_FIX;
  assign req2_next = (req2_reg & ~clr2) | set2;
  assign req3_next = (((req3_reg & ~clr3) | set3) & 8'hC3) | ISC_BANK3_FIX;

  // Sources ordered by priority, index 0 highest
  wire logic [15:0] src_flag = {req3_reg[7:6], req3_reg[1], req2_reg[5:0],
                                req3_reg[0], req1_reg[5:0]};
  wire logic [15:0] src_en   = {en3_reg[7:6], en3_reg[1], en2_reg[5:0],
                                en3_reg[0], en1_reg[5:0]};
  wire logic [15:0] src_act  = src_flag & src_en;
  logic [3:0] win_idx;
  always_comb begin
    win_idx = 4'h0;
    for (int i = ISC_NSRC - 1; i >= 0; i--) begin
      if (src_act[i])
        win_idx = 4'(i);
    end
  end
  // Slot number is the priority index; serial and A/D vectors come from the table
  wire logic [3:0] slot = win_idx;
  wire logic [15:0] slot_vec = (win_idx == 4'hD) ? ISC_VEC_SER1 :
                               (win_idx == 4'hE) ? ISC_VEC_SER1 + 16'h0002 :
                               (win_idx == 4'hF) ? ISC_VEC_ADC :
                               vec_of(slot);
  wire logic any_act = |src_act;
  wire logic accept  = any_act && !global_mask_i && insn_done_i;

  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (hit_pmr)  rd_mux = pmr_reg;
    if (hit_edge) rd_mux = edge_reg;
    if (hit_en1)  rd_mux = en1_reg;
    if (hit_en2)  rd_mux = en2_reg;
    if (hit_en3)  rd_mux = en3_reg;
    if (hit_req1) rd_mux = req1_reg;
    if (hit_req2) rd_mux = req2_reg;
    if (hit_req3) rd_mux = req3_reg;
    if (hit_stat) rd_mux = {irq_reg, 3'h0, pend_idx_reg};
  end

  // Bus slave: one wait cycle, answer on the second edge
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      bus_state_reg <= ISC_BUS_IDLE;
      rdata_reg     <= 8'h00;
    end else begin
      case (bus_state_reg)
        ISC_BUS_IDLE: begin
          if (bus_req) begin
            bus_state_reg <= ISC_BUS_DONE;
            rdata_reg     <= rd_mux;
          end
        end
        ISC_BUS_DONE: bus_state_reg <= ISC_BUS_IDLE;
        default:      bus_state_reg <= ISC_BUS_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      pmr_reg  <= ISC_PMR_RST;
      edge_reg <= ISC_EDGE_RST;
      en1_reg  <= ISC_EN1_RST;
      en2_reg  <= ISC_EN2_RST;
      en3_reg  <= ISC_EN3_RST;
    end else if (wr_take) begin
      if (hit_pmr)  pmr_reg  <= wd;
      if (hit_edge) edge_reg <= (wd & 8'h13) | ISC_EDGE_FIX;
      if (hit_en1)  en1_reg  <= (wd & 8'h3F) | ISC_BANK_FIX;
      if (hit_en2)  en2_reg  <= wd;
      if (hit_en3)  en3_reg  <= (wd & 8'hC3) | ISC_BANK3_FIX;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      req1_reg <= ISC_REQ1_RST;
      req2_reg <= ISC_REQ2_RST;
      req3_reg <= ISC_REQ3_RST;
    end else begin
      req1_reg <= req1_next;
      req2_reg <= req2_next;
      req3_reg <= req3_next;
    end
  end

  // Idle pins high so reset does not fake a falling edge
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      pin_prev_reg  <= 7'h7F;
      ext0_prev_reg <= 1'b1;
      osc_prev_reg  <= 1'b0;
    end else begin
      pin_prev_reg  <= port1_pins_i;
      ext0_prev_reg <= ext0_lvl;
      osc_prev_reg  <= osc_wait_done_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      filt_cnt_reg  <= 8'h00;
      filt_samp_reg <= 1'b1;
      filt_out_reg  <= 1'b1;
    end else begin
      filt_cnt_reg <= filt_tick ? 8'h00 : filt_cnt_reg + 8'h01;
      if (filt_tick) begin
        filt_samp_reg <= port1_pins_i[0];
        if (filt_samp_reg == port1_pins_i[0])
          filt_out_reg <= port1_pins_i[0];
      end
    end
  end

  // Request held from instruction boundary until the core acknowledges or the global mask is set
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      irq_reg      <= 1'b0;
      vec_reg      <= ISC_VEC_RESET;
      pend_idx_reg <= 4'h0;
    end else if (irq_reg) begin
      if (irq_ack_i || global_mask_i)
        irq_reg <= 1'b0;
    end else if (accept) begin
      irq_reg      <= 1'b1;
      vec_reg      <= slot_vec;
      pend_idx_reg <= win_idx;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i)
      event_reg <= 1'b1;
    else
      event_reg <= pmr_reg[ISC_PMR_EVENT] ? port1_pins_i[6] : 1'b1;
  end

  assign avs_readdata_o    = rdata_reg;
  assign avs_waitrequest_o = bus_req && (bus_state_reg == ISC_BUS_IDLE);
  assign irq_req_o         = irq_reg;
  assign irq_vector_o      = vec_reg;
  assign event_count_o     = event_reg;
  assign event_sel_o       = pmr_reg[ISC_PMR_EVENT];
  assign port_gpio_sel_o   = ~pmr_reg[5:0];

endmodule

// >>> src/isc_pkg.sv
// Register map, reset values and vector table of the interrupt controller
package isc_pkg;
  localparam logic [15:0] ISC_PMR_ADDR   = 16'hFFEB;
  localparam logic [15:0] ISC_EDGE_ADDR  = 16'hFFF2;
  localparam logic [15:0] ISC_EN1_ADDR   = 16'hFFF3;
  localparam logic [15:0] ISC_EN2_ADDR   = 16'hFFF4;
  localparam logic [15:0] ISC_EN3_ADDR   = 16'hFFF5;
  localparam logic [15:0] ISC_REQ1_ADDR  = 16'hFFF6;
  localparam logic [15:0] ISC_REQ2_ADDR  = 16'hFFF7;
  localparam logic [15:0] ISC_REQ3_ADDR  = 16'hFFF8;
  localparam logic [15:0] ISC_CTRL_ADDR  = 16'hFFF9;
  localparam logic [15:0] ISC_STAT_ADDR  = 16'hFFFA;

  localparam logic [7:0] ISC_PMR_RST   = 8'h00;
  localparam logic [7:0] ISC_EDGE_RST  = 8'hEC;
  localparam logic [7:0] ISC_EN1_RST   = 8'hC0;
  localparam logic [7:0] ISC_EN2_RST   = 8'h00;
  localparam logic [7:0] ISC_EN3_RST   = 8'h3C;
  localparam logic [7:0] ISC_REQ1_RST  = 8'hC0;
  localparam logic [7:0] ISC_REQ2_RST  = 8'h00;
  localparam logic [7:0] ISC_REQ3_RST  = 8'h3C;
  // Reserved bits that read one and ignore writes
  localparam logic [7:0] ISC_EDGE_FIX  = 8'hEC;
  localparam logic [7:0] ISC_BANK_FIX  = 8'hC0;
  localparam logic [7:0] ISC_BANK3_FIX = 8'h3C;

  localparam int ISC_PMR_NOISE = 7;
  localparam int ISC_PMR_EVENT = 6;
  localparam int ISC_PMR_EXT5  = 5;

  localparam int ISC_FILT_STATES = 256;

  localparam logic [15:0] ISC_VEC_RESET = 16'h0000;
  localparam logic [15:0] ISC_VEC_EXT0  = 16'h0008;
  localparam logic [15:0] ISC_VEC_KEY   = 16'h0014;
  localparam logic [15:0] ISC_VEC_TMRA  = 16'h0016;
  localparam logic [15:0] ISC_VEC_DIRT  = 16'h0020;
  localparam logic [15:0] ISC_VEC_SER1  = 16'h0026;
  localparam logic [15:0] ISC_VEC_ADC   = 16'h002A;

  localparam int ISC_NSRC = 16;

  typedef enum logic [1:0] {
    ISC_BUS_IDLE,
    ISC_BUS_DONE
  } isc_bus_t;
endpackage

// >>> testbench/isc_top_sva.sv
// Port-level checks for the interrupt source controller
`timescale 1ns/1ps
module isc_top_sva
  import isc_pkg::*;
(
  input wire logic        sys_clk_i,
  input wire logic        sys_rst_i,
  input wire logic [15:0] avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [7:0]  avs_writedata_i,
  input wire logic        avs_waitrequest_o,
  input wire logic [6:0]  port1_pins_i,
  input wire logic        global_mask_i,
  input wire logic        insn_done_i,
  input wire logic        irq_ack_i,
  input wire logic        irq_req_o,
  input wire logic [15:0] irq_vector_o,
  input wire logic        event_count_o,
  input wire logic        event_sel_o,
  input wire logic [5:0]  port_gpio_sel_o
);
  logic [7:0] pmr_reg;
  wire logic  pmr_wr;
  // Shadow taken at the completing edge, so it never leads the design
  assign pmr_wr = avs_write_i && !avs_waitrequest_o
                  && avs_address_i == ISC_PMR_ADDR;
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      pmr_reg <= 8'h00;
    end else if (pmr_wr) begin
      pmr_reg <= avs_writedata_i;
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_mask;
    global_mask_i |=> !irq_req_o;
  endproperty
  a_mask: assert property (p_mask)
    else $error("request while masked");
  property p_accept;
    $rose(irq_req_o) |-> $past(insn_done_i) && !$past(global_mask_i);
  endproperty
  a_accept: assert property (p_accept)
    else $error("accept off boundary");
  property p_hold;
    irq_req_o && !irq_ack_i && !global_mask_i
      |=> irq_req_o && $stable(irq_vector_o);
  endproperty
  a_hold: assert property (p_hold)
    else $error("request not held");
  property p_ack;
    irq_req_o && irq_ack_i |=> !irq_req_o;
  endproperty
  a_ack: assert property (p_ack)
    else $error("request not dropped");
  property p_vec;
    irq_req_o |-> !irq_vector_o[0] && irq_vector_o inside
      {[16'h0008:16'h0020], 16'h0026, 16'h0028, 16'h002A};
  endproperty
  a_vec: assert property (p_vec)
    else $error("bad vector");
  property p_wait;
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
  endproperty
  a_wait: assert property (p_wait)
    else $error("wait too long");
  property p_pinsel;
    !avs_write_i |-> port_gpio_sel_o == ~pmr_reg[5:0]
      && event_sel_o == pmr_reg[6];
  endproperty
  a_pinsel: assert property (p_pinsel)
    else $error("pin select wrong");
  property p_event;
    $stable(event_sel_o) |->
      event_count_o == (event_sel_o ? $past(port1_pins_i[6]) : 1'b1);
  endproperty
  a_event: assert property (p_event)
    else $error("event pin wrong");
endmodule
bind isc_top isc_top_sva i_sva (.sys_clk_i, .sys_rst_i, .avs_address_i,
  .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_waitrequest_o,
  .port1_pins_i, .global_mask_i, .insn_done_i, .irq_ack_i, .irq_req_o,
  .irq_vector_o, .event_count_o, .event_sel_o, .port_gpio_sel_o);

// >>> testbench/isc_core_model.sv
// Processor core model: instruction boundaries and vector fetch
`timescale 1ns/1ps
module isc_core_model (
  input  wire logic sys_clk_i,
  input  wire logic sys_rst_i,
  input  wire logic irq_req_i,
  input  wire logic slow_i,
  output logic      insn_done_o,
  output logic      irq_ack_o
);
  logic [1:0] step_reg;
  logic       ins_reg;
  // Boundary every other cycle, so an accept has to wait for it
  always_ff @(posedge sys_clk_i) begin
    ins_reg <= !sys_rst_i && !ins_reg;
  end
  assign insn_done_o = ins_reg;
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || !irq_req_i || irq_ack_o) begin
      step_reg  <= 2'h0;
      irq_ack_o <= 1'b0;
    end else begin
      step_reg  <= step_reg + 2'h1;
      irq_ack_o <= !slow_i || step_reg == 2'h3;
    end
  end
endmodule

// >>> testbench/interrupt_source_controller_tb_top.sv
// Self-checking bench for the interrupt source controller
`timescale 1ns/1ps
module interrupt_source_controller_tb_top
  import isc_pkg::*;
;
  logic        sys_clk_i, sys_rst_i, avs_read_i, avs_write_i, global_mask_i;
  logic        key_scan_req_i, osc_wait_done_i, serial_one_req_i, slow_i;
  logic        serial_two_req_i, adc_done_req_i, insn_done_i, irq_ack_i;
  logic        avs_waitrequest_o, irq_req_o, event_count_o, event_sel_o;
  logic [15:0] avs_address_i, irq_vector_o, a;
  logic [7:0]  avs_writedata_i, avs_readdata_o;
  logic [6:0]  port1_pins_i;
  logic [5:0]  port_gpio_sel_o;
  logic [4:0]  timer_ovf_req_i;
  logic [15:0] rq[$], vq[$];
  logic [7:0]  rst_exp [7] = '{8'hEC, 8'hC0, 8'h00, 8'h3C, 8'hC0, 8'h00, 8'h3C};
  int          failures = 0, n_tests = 0, cyc = 0;
  isc_top #(.FILT_STATES(4)) i_dut (.sys_clk_i, .sys_rst_i, .avs_address_i,
    .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_readdata_o,
    .avs_waitrequest_o, .port1_pins_i, .global_mask_i, .insn_done_i,
    .irq_ack_i, .key_scan_req_i, .timer_ovf_req_i, .osc_wait_done_i,
    .serial_one_req_i, .serial_two_req_i, .adc_done_req_i, .irq_req_o,
    .irq_vector_o, .event_count_o, .event_sel_o, .port_gpio_sel_o);
  isc_core_model i_core (.sys_clk_i, .sys_rst_i, .irq_req_i(irq_req_o),
    .slow_i, .insn_done_o(insn_done_i), .irq_ack_o(irq_ack_i));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic xfer(input logic wr, input logic [15:0] ad,
                      input logic [7:0] d);
    if (!wr)
      rq.push_back({8'h00, d});
    @(posedge sys_clk_i);
    avs_address_i   <= ad;
    avs_writedata_i <= d;
    avs_write_i     <= wr;
    avs_read_i      <= !wr;
    do @(posedge sys_clk_i); while (avs_waitrequest_o);
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
  endtask
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge sys_clk_i);
      port1_pins_i[6] <= 1'($urandom);
    end
  endtask
  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    cyc++;
    if (!sys_rst_i && avs_read_i && !avs_waitrequest_o)
      check({8'h00, avs_readdata_o}, rq.pop_front());
    if (!sys_rst_i && irq_req_o && irq_ack_i)
      check(irq_vector_o, vq.pop_front());
    if (cyc == 20000) begin
      failures++;
      conclude();
    end
  end
  initial begin
    void'($urandom(32'hF5FBEC12));
    {sys_rst_i, global_mask_i, port1_pins_i} = {2'b11, 7'h7F};
    {avs_read_i, avs_write_i, avs_address_i, avs_writedata_i} = '0;
    {key_scan_req_i, timer_ovf_req_i, osc_wait_done_i, slow_i} = '0;
    {serial_one_req_i, serial_two_req_i, adc_done_req_i} = '0;
    repeat (16) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    xfer(1'b0, ISC_PMR_ADDR, 8'h00);
    for (int k = 0; k < 7; k++)
      xfer(1'b0, 16'hFFF2 + 16'(k), rst_exp[k]);
    xfer(1'b1, 16'h0100, 8'h5A);
    xfer(1'b0, 16'h0100, 8'h00);
    $display("reset test end");
    port1_pins_i[5:0] <= 6'h00;
    idle(4);
    xfer(1'b0, ISC_REQ1_ADDR, 8'hC0);
    port1_pins_i[5:0] <= 6'h3F;
    xfer(1'b1, ISC_PMR_ADDR, 8'h3F);
    xfer(1'b1, ISC_EDGE_ADDR, 8'hFF);
    xfer(1'b0, ISC_EDGE_ADDR, 8'hFF);
    port1_pins_i[5:0] <= 6'h00;
    idle(4);
    xfer(1'b0, ISC_REQ1_ADDR, 8'hEC);
    port1_pins_i[5:0] <= 6'h3F;
    idle(4);
    xfer(1'b0, ISC_REQ1_ADDR, 8'hFF);
    $display("edge test end");
    {key_scan_req_i, timer_ovf_req_i, osc_wait_done_i} <= 7'h7F;
    {serial_one_req_i, serial_two_req_i, adc_done_req_i} <= 3'h7;
    idle(1);
    {key_scan_req_i, timer_ovf_req_i, osc_wait_done_i} <= 7'h00;
    {serial_one_req_i, serial_two_req_i, adc_done_req_i} <= 3'h0;
    xfer(1'b1, ISC_EN1_ADDR, 8'h3F);
    xfer(1'b1, ISC_EN2_ADDR, 8'h3F);
    xfer(1'b1, ISC_EN3_ADDR, 8'hFF);
    xfer(1'b0, ISC_REQ2_ADDR, 8'h3F);
    xfer(1'b0, ISC_REQ3_ADDR, 8'hFF);
    $display("masked test end");
    for (int i = 0; i < 16; i++) begin
      a = i < 6 ? ISC_REQ1_ADDR
        : (i == 6 || i > 12) ? ISC_REQ3_ADDR : ISC_REQ2_ADDR;
      vq.push_back(16'h0008 + 16'(2 * i) + (i > 12 ? 16'h4 : 16'h0));
      slow_i <= 1'($urandom);
      global_mask_i <= 1'b0;
      do @(posedge sys_clk_i); while (!(irq_req_o && irq_ack_i));
      global_mask_i <= 1'b1;
      xfer(1'b1, a, ~(8'h01 << (i < 6 ? i : i == 6 ? 0 : i < 13 ? i - 7
                               : i == 13 ? 1 : i - 8)));
    end
    xfer(1'b0, ISC_REQ1_ADDR, 8'hC0);
    xfer(1'b0, ISC_REQ2_ADDR, 8'h00);
    xfer(1'b0, ISC_REQ3_ADDR, 8'h3C);
    $display("priority test end");
    xfer(1'b1, ISC_EDGE_ADDR, 8'h00);
    xfer(1'b1, ISC_PMR_ADDR, 8'hC1);
    idle(12 + $urandom % 4);
    port1_pins_i[0] <= 1'b0;
    idle(1);
    port1_pins_i[0] <= 1'b1;
    idle(20);
    xfer(1'b0, ISC_REQ1_ADDR, 8'hC0);
    port1_pins_i[0] <= 1'b0;
    idle(20);
    xfer(1'b0, ISC_REQ1_ADDR, 8'hC1);
    $display("filter test end");
    conclude();
  end
endmodule
